// ---- hw/memmap_pkg.sv ----
package memmap_pkg;
   localparam int          ADDR_W          = 20;
   localparam logic [19:0] FUNC_LO         = 20'h0_0000;
   localparam logic [19:0] FUNC_HI         = 20'h0_03FF;
   localparam logic [19:0] RAM_BASE        = 20'h0_0400;
   localparam logic [19:0] ROM_TOP         = 20'hF_FFFF;
   localparam logic [19:0] SPV_LO          = 20'hF_FE00;
   localparam logic [19:0] SPV_HI          = 20'hF_FFDB;
   localparam logic [19:0] FIXV_LO         = 20'hF_FFDC;
   localparam int unsigned RAM_BYTES_DEF   = 32'h0000_1400;
   localparam int unsigned ROM_BYTES_DEF   = 32'h0002_0000;
   localparam int          SEL_W           = 4;
   localparam int          SEL_FUNC        = 0;
   localparam int          SEL_RAM         = 1;
   localparam int          SEL_ROM         = 2;
   localparam int          SEL_EXT         = 3;
endpackage

// ---- hw/region_match.sv ----
`timescale 1ns/1ps
module region_match
   import memmap_pkg::*;
#(
   parameter logic [19:0] LO = 20'h0_0000,
   parameter logic [19:0] HI = 20'h0_0000
) (
   input  wire logic [19:0] addr,
   output logic             hit
);
   assign hit = (addr >= LO) && (addr <= HI);
endmodule

// ---- hw/memory_map_address_decoder.sv ----
// Functional notes
// - Accept 20-bit addresses spanning the whole 1 Mbyte space.
// - Internal ROM ends at FFFFF and grows downward by ROM size.
// - FFFDC to FFFFF decode as the fixed interrupt vector table.
// - Internal RAM starts at 00400 and grows upward by RAM size.
// - Stack pushes from calls and interrupts are checked against internal RAM; one outside it sets stack_miss.
// - 00000 to 003FF select the special function register area.
// - FFE00 to FFFDB decode as the special page vector table.
`timescale 1ns/1ps
module memory_map_address_decoder
   import memmap_pkg::*;
#(
   parameter int unsigned RAM_BYTES = RAM_BYTES_DEF,
   parameter int unsigned ROM_BYTES = ROM_BYTES_DEF
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              addr_valid,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              stack_access,
   output logic                   out_valid,
   output logic [ADDR_W-1:0]      out_addr,
   output logic [SEL_W-1:0]       region_sel,
   output logic                   special_page_vec,
   output logic                   fixed_vec,
   output logic                   stack_in_ram,
   output logic                   stack_miss
);
   // Region limits derived from the size parameters
   localparam logic [ADDR_W-1:0] RAM_LAST  = 20'(RAM_BASE + RAM_BYTES - 1);
   localparam logic [ADDR_W-1:0] ROM_FIRST = 20'(ROM_TOP - ROM_BYTES + 1);

   // Comparator slots
   localparam int WIN_N    = 5;
   localparam int WIN_FUNC = 0;
   localparam int WIN_RAM  = 1;
   localparam int WIN_ROM  = 2;
   localparam int WIN_SPV  = 3;
   localparam int WIN_FIXV = 4;

   // Bounds per slot, highest slot leftmost
   localparam logic [WIN_N-1:0][ADDR_W-1:0] WIN_LO = {
      FIXV_LO,
      SPV_LO,
      ROM_FIRST,
      RAM_BASE,
      FUNC_LO
   };
   localparam logic [WIN_N-1:0][ADDR_W-1:0] WIN_HI = {
      ROM_TOP,
      SPV_HI,
      ROM_TOP,
      RAM_LAST,
      FUNC_HI
   };

   // Priority order keeps the selects one-hot even if sizes make regions overlap
   typedef enum logic [1:0] {
      KIND_FUNC = 2'h0,
      KIND_RAM  = 2'h1,
      KIND_ROM  = 2'h3,
      KIND_EXT  = 2'h2
   } region_kind_t;

   logic [WIN_N-1:0]       win_hit;
   logic                   hit_func;
   logic                   hit_ram;
   logic                   hit_rom;
   logic                   hit_spv;
   logic                   hit_fixv;
   region_kind_t           kind;

   // Request echo group
   logic                   valid_d;
   logic                   valid_q;
   logic [ADDR_W-1:0]      addr_d;
   logic [ADDR_W-1:0]      addr_q;

   // Region select group
   logic [SEL_W-1:0]       sel_d;
   logic [SEL_W-1:0]       sel_q;

   // Vector flag group
   logic                   spv_d;
   logic                   spv_q;
   logic                   fixv_d;
   logic                   fixv_q;

   // Stack flag group
   logic                   stk_ok_d;
   logic                   stk_ok_q;
   logic                   stk_miss_d;
   logic                   stk_miss_q;

   // One comparator per slot, all on the raw bus address
   for (genvar i = 0; i < WIN_N; i++) begin : g_win
      region_match #(
         .LO (WIN_LO[i]),
         .HI (WIN_HI[i])
      ) u_match (
         .addr (addr),
         .hit  (win_hit[i])
      );
   end

   // Slot hits by name
   assign hit_func = win_hit[WIN_FUNC];
   assign hit_ram  = win_hit[WIN_RAM];
   assign hit_rom  = win_hit[WIN_ROM];
   assign hit_spv  = win_hit[WIN_SPV];
   assign hit_fixv = win_hit[WIN_FIXV];

   always_comb begin
      if (hit_func) begin
         kind = KIND_FUNC;
      end else if (hit_ram) begin
         kind = KIND_RAM;
      end else if (hit_rom) begin
         kind = KIND_ROM;
      end else begin
         kind = KIND_EXT;
      end
   end

   // Echo the request so the target sees address and select together
   always_comb begin
      valid_d = addr_valid;
      addr_d  = addr;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         valid_q <= 1'b0;
         addr_q  <= 20'h0_0000;
      end else begin
         valid_q <= valid_d;
         addr_q  <= addr_d;
      end
   end

   // Idle cycles drive no select at all
   always_comb begin
      sel_d = '0;
      if (addr_valid) begin
         // Kind covers all four codes, so no default
         unique case (kind)
            KIND_FUNC: begin
               sel_d[SEL_FUNC] = 1'b1;
            end
            KIND_RAM: begin
               sel_d[SEL_RAM] = 1'b1;
            end
            KIND_ROM: begin
               sel_d[SEL_ROM] = 1'b1;
            end
            KIND_EXT: begin
               sel_d[SEL_EXT] = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_q <= '0;
      end else begin
         sel_q <= sel_d;
      end
   end

   // Vector flags ride only on a ROM select; too small a ROM leaves them dark
   always_comb begin
      spv_d  = 1'b0;
      fixv_d = 1'b0;
      if (addr_valid && (kind == KIND_ROM)) begin
         spv_d  = hit_spv;
         fixv_d = hit_fixv;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         spv_q  <= 1'b0;
         fixv_q <= 1'b0;
      end else begin
         spv_q  <= spv_d;
         fixv_q <= fixv_d;
      end
   end

   // Stack traffic must land in RAM; a stray stack pointer is flagged
   always_comb begin
      stk_ok_d   = 1'b0;
      stk_miss_d = 1'b0;
      if (addr_valid && stack_access) begin
         stk_ok_d   = (kind == KIND_RAM);
         stk_miss_d = (kind != KIND_RAM);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stk_ok_q   <= 1'b0;
         stk_miss_q <= 1'b0;
      end else begin
         stk_ok_q   <= stk_ok_d;
         stk_miss_q <= stk_miss_d;
      end
   end

   // Every output straight from its flop
   assign out_valid        = valid_q;
   assign out_addr         = addr_q;
   assign region_sel       = sel_q;
   assign special_page_vec = spv_q;
   assign fixed_vec        = fixv_q;
   assign stack_in_ram     = stk_ok_q;
   assign stack_miss       = stk_miss_q;
endmodule

// ---- bench/decoder_asserts.sv ----
`timescale 1ns/1ps
module decoder_asserts
   import memmap_pkg::*;
#(
   parameter int unsigned RAM_BYTES = RAM_BYTES_DEF,
   parameter int unsigned ROM_BYTES = ROM_BYTES_DEF
) (
   input wire logic              clk,
   input wire logic              resetn,
   input wire logic              addr_valid,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              stack_access,
   input wire logic              out_valid,
   input wire logic [ADDR_W-1:0] out_addr,
   input wire logic [SEL_W-1:0]  region_sel,
   input wire logic              special_page_vec,
   input wire logic              fixed_vec,
   input wire logic              stack_in_ram,
   input wire logic              stack_miss
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Expected classes rebuilt from the sizes, highest priority first
   wire v      = addr_valid;
   wire func   = addr <= FUNC_HI;
   wire ram    = !func && addr >= RAM_BASE && addr < RAM_BASE + RAM_BYTES;
   wire rom    = !func && !ram && addr >= 21'h10_0000 - ROM_BYTES;
   wire spv    = rom && addr inside {[SPV_LO:SPV_HI]};
   wire fixv   = rom && addr >= FIXV_LO;
   wire stk_ok = stack_access && ram;
   wire stk_no = stack_access && !ram;
   a_func_sel: assert property (v && func |=> region_sel == 4'h1)
      else $error("Register area address without its select");
   a_ram_sel: assert property (v && ram |=> region_sel == 4'h2)
      else $error("RAM address without its select");
   a_rom_sel: assert property (v && rom |=> region_sel == 4'h4)
      else $error("ROM address without its select");
   a_ext_sel: assert property (v && !func && !ram && !rom |=> region_sel == 4'h8)
      else $error("Unmapped address without the external select");
   a_fixed_vec: assert property (v |=> fixed_vec == $past(fixv))
      else $error("Fixed vector flag wrong");
   a_page_vec: assert property (v |=> special_page_vec == $past(spv))
      else $error("Special page vector flag wrong");
   a_stack_ram: assert property (v |=> stack_in_ram == $past(stk_ok))
      else $error("Stack in RAM flag wrong");
   a_stack_miss: assert property (v |=> stack_miss == $past(stk_no))
      else $error("Stack miss flag wrong");
   a_one_hot: assert property (out_valid |-> $onehot(region_sel))
      else $error("Region select not one-hot");
   a_idle_quiet: assert property (!v |=> !out_valid && region_sel == 4'h0 && !fixed_vec && !special_page_vec)
      else $error("Outputs active after an idle cycle");
   a_idle_stack: assert property (!v |=> !stack_in_ram && !stack_miss)
      else $error("Stack flags active after an idle cycle");
   a_addr_echo: assert property (v |=> out_valid && out_addr == $past(addr))
      else $error("Address echo wrong");
endmodule
bind memory_map_address_decoder decoder_asserts #(
   .RAM_BYTES (RAM_BYTES),
   .ROM_BYTES (ROM_BYTES)
) chk (
   .clk              (clk),
   .resetn           (resetn),
   .addr_valid       (addr_valid),
   .addr             (addr),
   .stack_access     (stack_access),
   .out_valid        (out_valid),
   .out_addr         (out_addr),
   .region_sel       (region_sel),
   .special_page_vec (special_page_vec),
   .fixed_vec        (fixed_vec),
   .stack_in_ram     (stack_in_ram),
   .stack_miss       (stack_miss)
);

// ---- bench/cpu_master.sv ----
`timescale 1ns/1ps
module cpu_master (
   input  wire logic   clk,
   output logic        addr_valid = 1'b0,
   output logic        stack_access = 1'b0,
   output logic [19:0] addr = 20'h0_0000
);
   task automatic issue(input logic [19:0] x, input logic s);
      @(posedge clk);
      {addr_valid, addr, stack_access} <= {1'b1, x, s};
      @(posedge clk);
      {addr_valid, addr, stack_access} <= {1'b0, ~x, ~s}; // Junk when idle, so stale values cannot pass
   endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
   logic        clk = 1'b0, resetn = 1'b0, addr_valid, stack_access, out_valid;
   logic        special_page_vec, fixed_vec, stack_in_ram, stack_miss;
   logic [19:0] addr, out_addr;
   logic [3:0]  region_sel;
   int          errors = 0, tests_run = 0;
   always #4 clk = ~clk;
   cpu_master cpu (
      .clk          (clk),
      .addr_valid   (addr_valid),
      .stack_access (stack_access),
      .addr         (addr)
   );
   memory_map_address_decoder uut (
      .clk              (clk),
      .resetn           (resetn),
      .addr_valid       (addr_valid),
      .addr             (addr),
      .stack_access     (stack_access),
      .out_valid        (out_valid),
      .out_addr         (out_addr),
      .region_sel       (region_sel),
      .special_page_vec (special_page_vec),
      .fixed_vec        (fixed_vec),
      .stack_in_ram     (stack_in_ram),
      .stack_miss       (stack_miss)
   );
   task automatic chk(input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Code c holds {stack, select, page vec, fixed vec}
   task automatic dec(input logic [19:0] x, input logic [6:0] c);
      logic [31:0] want;
      want = {3'h0, 1'b1, x, c[5:0], c[6] & c[3], c[6] & ~c[3]};
      cpu.issue(x, c[6]);
      #1;
      chk({3'h0, out_valid, out_addr, region_sel, special_page_vec, fixed_vec, stack_in_ram, stack_miss}, want);
   endtask
   // Reset in mid-run clears a result in flight; decoding resumes the cycle after release
   task automatic t_reset;
      cpu.issue(20'h0_0400, 1'b1);
      resetn <= 1'b0;
      #1;
      chk({3'h0, out_valid, out_addr, region_sel, special_page_vec, fixed_vec, stack_in_ram, stack_miss}, 32'h0);
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      dec(20'h0_0000, 7'h44);
      $display("reset test done");
   endtask
   task automatic t_low;
      dec(20'h0_03FF, 7'h04);
      dec(20'h0_0400, 7'h48);
      dec(20'h0_17FF, 7'h48);
      dec(20'h0_1800, 7'h60);
      $display("low map done");
   endtask
   task automatic t_high;
      dec(20'hD_FFFF, 7'h20);
      dec(20'hE_0000, 7'h10);
      dec(20'hF_FE00, 7'h12);
      dec(20'hF_FFDB, 7'h12);
      dec(20'hF_FFDC, 7'h51);
      dec(20'hF_FFFF, 7'h11);
      @(posedge clk);
      #1;
      chk({27'h0, out_valid, region_sel}, 32'h0000_0000);
      $display("high map done");
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_low;
      t_reset;
      t_high;
      final_report;
   end
   initial begin
      #20000;
      errors++;
      final_report;
   end
endmodule
